// ### conv_regs_pkg.sv
/*
  Constants and carrier types shared by the converter result and trigger
  register logic: byte offsets, field positions, reset values and the
  trigger source codes.
  Assumes a byte-wide register port with 8-bit addresses.
*/
`default_nettype none

package conv_regs_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] off_result_low    = 8'h78;
  localparam logic [7:0] off_result_high   = 8'h79;
  localparam logic [7:0] off_conv_control  = 8'h7a;
  localparam logic [7:0] off_trigger_ctrl  = 8'h7b;
  localparam logic [7:0] off_channel_align = 8'h7c;
  localparam logic [7:0] off_input_disable = 8'h7e;

  // ==========================================================================
  // Field positions
  localparam int pos_converter_enable   = 7;
  localparam int pos_auto_trigger       = 5;
  localparam int pos_complete_flag      = 4;
  localparam int pos_comparator_mux     = 6;
  localparam int pos_trigger_reserved   = 7;
  localparam int pos_left_align         = 5;
  localparam int pos_trigger_field_hi   = 2;
  localparam int pos_channel_code_hi    = 4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] rst_byte       = 8'h00;
  localparam logic [9:0] rst_result     = 10'h000;
  localparam logic [2:0] rst_trigger    = 3'h0;
  localparam logic [4:0] rst_channel    = 5'h00;

  // ==========================================================================
  // Channel codes that mark a differential pair
  localparam logic [4:0] chan_diff_first = 5'h10;
  localparam logic [4:0] chan_diff_last  = 5'h1d;

  // ==========================================================================
  // Trigger source codes
  typedef enum logic [2:0] {
    trig_free_running  = 3'b000,
    trig_comparator    = 3'b001,
    trig_ext_irq0      = 3'b010,
    trig_t0_compare    = 3'b011,
    trig_t0_overflow   = 3'b100,
    trig_t_compare_b   = 3'b101,
    trig_t1_overflow   = 3'b110,
    trig_t1_capture    = 3'b111
  } trigger_source_t;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic comparator;
    logic ext_irq0;
    logic t0_compare;
    logic t0_overflow;
    logic t_compare_b;
    logic t1_overflow;
    logic t1_capture;
  } trigger_flags_t;

  typedef struct packed {
    logic       done;
    logic [9:0] value;
  } conv_result_t;

endpackage

`default_nettype wire

// ### trigger_edge.sv
/*
  Rising edge detector for the selected trigger level, with a suppress
  input that swallows an edge in the cycle it is asserted.
  Assumes the level comes from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module trigger_edge (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Level in, edge out
  input  wire logic level,
  input  wire logic suppress,
  output logic      rise
);

  logic prev_ff;

  // ==========================================================================
  // Previous level tracks always, even while suppressed
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level;
    end
  end

  // Edge only where the level was low one cycle ago
  assign rise = level & ~prev_ff & ~suppress;

endmodule

`default_nettype wire

// ### converter_result_trigger_regs.sv
/*
  Register side of a 10-bit converter: locked two-byte result with left or
  right alignment, auto trigger source selection with edge generation, and
  per-pin digital input buffer disable with masked pin readback.
  Registers kept here, all one byte wide:
    result low and high, read only, the pair locked by a low read;
    control with converter enable, auto trigger and a write-one-clear
    completion flag;
    trigger with comparator mux enable and a three-bit source field;
    channel with the alignment select and a five-bit channel code;
    input disable, one bit for each analog pin.
  The block only requests conversions; the analog core decides when a
  started conversion ends and reports it on conv_in.
  Assumes the analog core, trigger flags and register master share
  core_clk; analog pin levels arrive asynchronously.
  Assumes the master never raises read and write strobes together and
  never waits for an answer.
*/
`timescale 1ns/1ns
`default_nettype none

module converter_result_trigger_regs (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  // Register port
  input  wire conv_regs_pkg::reg_req_t        reg_req,
  output logic [7:0]                          reg_rdata,
  // Analog core
  input  wire conv_regs_pkg::conv_result_t    conv_in,
  output logic                                start_conversion,
  output logic                                converter_enable,
  // Trigger flags from peripherals
  input  wire conv_regs_pkg::trigger_flags_t  trig_flags,
  // Comparator
  output logic                                comparator_mux_enable,
  // Analog pins
  input  wire logic [7:0]                     pin_level,
  output logic [7:0]                          pin_buffer_disable_bits,
  output logic [7:0]                          pin_read_value
);

  // ==========================================================================
  // State
  logic [9:0] result_ff;
  logic       lock_ff;
  logic       flag_ff;
  logic       enable_ff;
  logic       auto_ff;
  logic       cme_ff;
  logic [2:0] trigger_source_field_ff;
  logic [2:0] src_prev_ff;
  logic       left_align_select_ff;
  logic [4:0] channel_code_ff;
  logic [7:0] disable_ff;
  logic [7:0] pin_meta_ff;
  logic [7:0] pin_sync_ff;
  logic [7:0] pin_read_ff;
  logic [7:0] rdata_ff;
  logic       start_ff;

  // ==========================================================================
  // Address decode
  // Exact byte decode; writes to read-only or unmapped offsets are
  // simply dropped, and unmapped reads return zero.
  logic wr_conv_control;
  logic wr_trigger_ctrl;
  logic wr_channel_align;
  logic wr_input_disable;
  logic rd_result_low;
  logic rd_result_high;

  assign wr_conv_control  = reg_req.wr && (reg_req.addr == conv_regs_pkg::off_conv_control);
  assign wr_trigger_ctrl  = reg_req.wr && (reg_req.addr == conv_regs_pkg::off_trigger_ctrl);
  assign wr_channel_align = reg_req.wr && (reg_req.addr == conv_regs_pkg::off_channel_align);
  assign wr_input_disable = reg_req.wr && (reg_req.addr == conv_regs_pkg::off_input_disable);
  assign rd_result_low    = reg_req.rd && (reg_req.addr == conv_regs_pkg::off_result_low);
  assign rd_result_high   = reg_req.rd && (reg_req.addr == conv_regs_pkg::off_result_high);

  // ==========================================================================
  // Result capture and read-order lock
  // A low read in the same cycle as a completion blocks the update, so the
  // high byte later read pairs with the low byte already returned.
  // A high read with no low read before it leaves the pair unlocked, which
  // suits software that only wants the top eight bits of a left result.
  // Trade-off: a result that lands while locked is lost, never queued.
  logic capture;
  logic nxt_lock_ff;
  logic flag_clear;
  logic nxt_flag_ff;

  assign capture     = conv_in.done && !lock_ff && !rd_result_low;
  assign nxt_lock_ff = rd_result_low ? 1'b1 :
                       rd_result_high ? 1'b0 : lock_ff;
  assign flag_clear  = wr_conv_control && reg_req.wdata[conv_regs_pkg::pos_complete_flag];
  // Set wins over a simultaneous write-one clear
  assign nxt_flag_ff = capture ? 1'b1 : (flag_clear ? 1'b0 : flag_ff);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result_ff <= conv_regs_pkg::rst_result;
      lock_ff   <= 1'b0;
      flag_ff   <= 1'b0;
    end else begin
      if (capture) begin
        result_ff <= conv_in.value;
      end
      lock_ff <= nxt_lock_ff;
      flag_ff <= nxt_flag_ff;
    end
  end

  // ==========================================================================
  // Result presentation, combinational so alignment acts at once
  logic       differential;
  logic [5:0] sign_fill;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;

  assign differential = (channel_code_ff >= conv_regs_pkg::chan_diff_first) &&
                        (channel_code_ff <= conv_regs_pkg::chan_diff_last);
  // Left alignment ignores the channel code: the sign already sits in
  // the top bit and the low six bits of the low byte read zero.
  // Differential results are signed; right aligned they sign-extend
  assign sign_fill    = differential ? {6{result_ff[9]}} : 6'h00;
  assign result_high_byte = left_align_select_ff ? result_ff[9:2] :
                            {sign_fill, result_ff[9:8]};
  assign result_low_byte  = left_align_select_ff ? {result_ff[1:0], 6'h00} :
                            result_ff[7:0];

  // ==========================================================================
  // Control registers written by software
  // Reserved trigger bit is never stored, so it always reads back zero.
  // Control bit 4 is the flag clear, handled with the flag above; the
  // other unstored control bits read back zero.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enable_ff               <= 1'b0;
      auto_ff                 <= 1'b0;
      cme_ff                  <= 1'b0;
      trigger_source_field_ff <= conv_regs_pkg::rst_trigger;
      left_align_select_ff    <= 1'b0;
      channel_code_ff         <= conv_regs_pkg::rst_channel;
      disable_ff              <= conv_regs_pkg::rst_byte;
    end else begin
      if (wr_conv_control) begin
        enable_ff <= reg_req.wdata[conv_regs_pkg::pos_converter_enable];
        auto_ff   <= reg_req.wdata[conv_regs_pkg::pos_auto_trigger];
      end
      if (wr_trigger_ctrl) begin
        cme_ff                  <= reg_req.wdata[conv_regs_pkg::pos_comparator_mux];
        trigger_source_field_ff <= reg_req.wdata[conv_regs_pkg::pos_trigger_field_hi:0];
      end
      if (wr_channel_align) begin
        left_align_select_ff <= reg_req.wdata[conv_regs_pkg::pos_left_align];
        channel_code_ff      <= reg_req.wdata[conv_regs_pkg::pos_channel_code_hi:0];
      end
      if (wr_input_disable) begin
        disable_ff <= reg_req.wdata;
      end
    end
  end

  // ==========================================================================
  // Trigger source selection
  // Free running watches the completion flag itself, so each completion
  // that sets a cleared flag retriggers; the flag is the only source the block owns.
  // Peripheral flags are taken as they come, with no synchroniser: they
  // are assumed to be driven from core_clk logic.
  logic trig_level;

  always_comb begin
    trig_level = 1'b0;
    case (conv_regs_pkg::trigger_source_t'(trigger_source_field_ff))
      conv_regs_pkg::trig_free_running: trig_level = flag_ff;
      conv_regs_pkg::trig_comparator:   trig_level = trig_flags.comparator;
      conv_regs_pkg::trig_ext_irq0:     trig_level = trig_flags.ext_irq0;
      conv_regs_pkg::trig_t0_compare:   trig_level = trig_flags.t0_compare;
      conv_regs_pkg::trig_t0_overflow:  trig_level = trig_flags.t0_overflow;
      conv_regs_pkg::trig_t_compare_b:  trig_level = trig_flags.t_compare_b;
      conv_regs_pkg::trig_t1_overflow:  trig_level = trig_flags.t1_overflow;
      conv_regs_pkg::trig_t1_capture:   trig_level = trig_flags.t1_capture;
      default:                          trig_level = 1'b0;
    endcase
  end

  // ==========================================================================
  // Edge generation
  // The edge history runs even with auto trigger off, so a later enable
  // does not fire on a flag that has stood high for a while.
  // Hazard accepted: a source switch compares the new level against the
  // old source's level, so a switch onto a set flag is a real edge, except a switch to free running, which is suppressed.
  // Start is registered, so it reaches the core one cycle after the edge.
  logic to_free_running;
  logic trig_rise;
  logic nxt_start_ff;

  assign to_free_running = (trigger_source_field_ff == conv_regs_pkg::trig_free_running) &&
                           (src_prev_ff != conv_regs_pkg::trig_free_running);

  trigger_edge u_trigger_edge (
    .core_clk (core_clk),
    .rstn     (rstn),
    .level    (trig_level),
    .suppress (to_free_running),
    .rise     (trig_rise)
  );

  // Start only with converter and auto trigger both enabled
  assign nxt_start_ff = trig_rise && auto_ff && enable_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      src_prev_ff <= conv_regs_pkg::rst_trigger;
      start_ff    <= 1'b0;
    end else begin
      src_prev_ff <= trigger_source_field_ff;
      start_ff    <= nxt_start_ff;
    end
  end

  // ==========================================================================
  // Pin input path
  // Two stages before the mask; a disabled pin reads zero whatever it holds.
  // Only the second stage feeds logic; the first may still be settling.
  // A disable write reaches the read value one cycle after it lands.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_ff <= conv_regs_pkg::rst_byte;
      pin_sync_ff <= conv_regs_pkg::rst_byte;
      pin_read_ff <= conv_regs_pkg::rst_byte;
    end else begin
      pin_meta_ff <= pin_level;
      pin_sync_ff <= pin_meta_ff;
      pin_read_ff <= pin_sync_ff & ~disable_ff;
    end
  end

  // ==========================================================================
  // Read data mux, answered in the cycle after the strobe
  // The read data fall back to zero when no read is made, so a stale
  // byte never stands on the port; reads have no side effects except
  // the lock handled with the result.
  logic [7:0] conv_control_rd;
  logic [7:0] trigger_ctrl_rd;
  logic [7:0] channel_align_rd;
  logic [7:0] nxt_rdata_ff;

  assign conv_control_rd  = {enable_ff, 1'b0, auto_ff, flag_ff, 4'h0};
  assign trigger_ctrl_rd  = {1'b0, cme_ff, 3'h0, trigger_source_field_ff};
  assign channel_align_rd = {2'h0, left_align_select_ff, channel_code_ff};

  always_comb begin
    nxt_rdata_ff = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        conv_regs_pkg::off_result_low:    nxt_rdata_ff = result_low_byte;
        conv_regs_pkg::off_result_high:   nxt_rdata_ff = result_high_byte;
        conv_regs_pkg::off_conv_control:  nxt_rdata_ff = conv_control_rd;
        conv_regs_pkg::off_trigger_ctrl:  nxt_rdata_ff = trigger_ctrl_rd;
        conv_regs_pkg::off_channel_align: nxt_rdata_ff = channel_align_rd;
        conv_regs_pkg::off_input_disable: nxt_rdata_ff = disable_ff;
        default:                          nxt_rdata_ff = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= conv_regs_pkg::rst_byte;
    end else begin
      rdata_ff <= nxt_rdata_ff;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops
  // No output is decoded combinationally, which keeps the timing of
  // the register port and the start pulse independent of the decode.
  assign reg_rdata               = rdata_ff;
  assign start_conversion        = start_ff;
  assign converter_enable        = enable_ff;
  assign comparator_mux_enable   = cme_ff;
  assign pin_buffer_disable_bits = disable_ff;
  assign pin_read_value          = pin_read_ff;

endmodule

`default_nettype wire

// ### converter_result_trigger_regs_props.sv
/*
  Port checker for the converter result and trigger register block.
  Assumes the bind below reaches every instance of the block.
*/
`timescale 1ns/1ns
`default_nettype none

module conv_regs_props (
  // Clock and reset
  input wire logic                           core_clk,
  input wire logic                           rstn,
  // Watched ports
  input wire conv_regs_pkg::reg_req_t        reg_req,
  input wire logic [7:0]                     reg_rdata,
  input wire conv_regs_pkg::conv_result_t    conv_in,
  input wire logic                           start_conversion,
  input wire logic                           converter_enable,
  input wire conv_regs_pkg::trigger_flags_t  trig_flags,
  input wire logic                           comparator_mux_enable,
  input wire logic [7:0]                     pin_level,
  input wire logic [7:0]                     pin_buffer_disable_bits,
  input wire logic [7:0]                     pin_read_value
);
  // ==========================================================================
  // Decoded strobes
  wire wr_ctrl = reg_req.wr && reg_req.addr == 8'h7a;
  wire wr_trig = reg_req.wr && reg_req.addr == 8'h7b;
  wire wr_dis  = reg_req.wr && reg_req.addr == 8'h7e;
  wire rd_trig = reg_req.rd && reg_req.addr == 8'h7b;
  wire rd_dis  = reg_req.rd && reg_req.addr == 8'h7e;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Register side
  property p_dis_wr; wr_dis |=> pin_buffer_disable_bits == $past(reg_req.wdata); endproperty
  a_dis_wr: assert property (p_dis_wr) else $error("disable bits not stored");
  property p_dis_rd; rd_dis |=> reg_rdata == pin_buffer_disable_bits; endproperty
  a_dis_rd: assert property (p_dis_rd) else $error("disable readback wrong");
  property p_trig_rsv; rd_trig |=> reg_rdata[7] == 1'b0 && reg_rdata[5:3] == 3'h0; endproperty
  a_trig_rsv: assert property (p_trig_rsv) else $error("reserved bits not zero");
  property p_cme; wr_trig |=> comparator_mux_enable == $past(reg_req.wdata[6]); endproperty
  a_cme: assert property (p_cme) else $error("mux enable not stored");
  property p_en; wr_ctrl |=> converter_enable == $past(reg_req.wdata[7]); endproperty
  a_en: assert property (p_en) else $error("enable not stored");

  // ==========================================================================
  // Pins and trigger; a mask may lag one cycle behind a disable write
  property p_mask; (pin_read_value & $past(pin_buffer_disable_bits)) == 8'h00; endproperty
  a_mask: assert property (p_mask) else $error("disabled pin reads one");
  property p_follow;
    $stable(pin_level)[*4] |-> pin_read_value == (pin_level & ~$past(pin_buffer_disable_bits));
  endproperty
  a_follow: assert property (p_follow) else $error("pin value not followed");
  property p_start_one; start_conversion |=> !start_conversion; endproperty
  a_start_one: assert property (p_start_one) else $error("start longer than one cycle");
  property p_start_en; start_conversion |-> converter_enable || $past(converter_enable); endproperty
  a_start_en: assert property (p_start_en) else $error("start while disabled");
endmodule

bind converter_result_trigger_regs conv_regs_props u_props (
  .core_clk(core_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .conv_in(conv_in), .start_conversion(start_conversion),
  .converter_enable(converter_enable), .trig_flags(trig_flags),
  .comparator_mux_enable(comparator_mux_enable), .pin_level(pin_level),
  .pin_buffer_disable_bits(pin_buffer_disable_bits), .pin_read_value(pin_read_value)
);
`default_nettype wire

// ### test_converter_result_trigger_regs.sv
/*
  Self-checking bench for the converter register block with a model.
  Assumes the block answers reads one cycle later and never stalls.
*/
`timescale 1ns/1ns
`default_nettype none

module test_converter_result_trigger_regs;
  logic                           core_clk = 1'b0;
  logic                           rstn;
  conv_regs_pkg::reg_req_t        reg_req;
  conv_regs_pkg::conv_result_t    conv_in;
  conv_regs_pkg::trigger_flags_t  trig_flags;
  logic [7:0]                     reg_rdata, pin_level, pin_buffer_disable_bits, pin_read_value;
  logic                           start_conversion, converter_enable, comparator_mux_enable;
  int                             n_mismatch, tests_run, n_start, i, k;
  logic [9:0]                     m_res;
  logic [4:0]                     m_ch;
  logic                           m_lock, m_flag, m_al, m_en, m_auto;
  logic [31:0]                    seed, x;
  logic [15:0]                    p;

  converter_result_trigger_regs u_dut (
    .core_clk(core_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .conv_in(conv_in), .start_conversion(start_conversion),
    .converter_enable(converter_enable), .trig_flags(trig_flags),
    .comparator_mux_enable(comparator_mux_enable), .pin_level(pin_level),
    .pin_buffer_disable_bits(pin_buffer_disable_bits), .pin_read_value(pin_read_value)
  );

  // ==========================================================================
  // Clock, start counter, hang guard
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (start_conversion === 1'b1) n_start++;
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    finish_test();
  end

  // ==========================================================================
  // Model helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // High and low byte as software should see them
  function automatic logic [15:0] pres(logic [9:0] r, logic al, logic [4:0] ch);
    if (al) return {r, 6'h00};
    return {{6{r[9] && ch >= 5'h10 && ch <= 5'h1d}}, r};
  endfunction

  task chk(input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge core_clk);
    reg_req <= {1'b1, 1'b0, a, d};
    @(posedge core_clk);
    reg_req <= '0;
    if (a == 8'h7a) begin
      m_en = d[7];
      m_auto = d[5];
      if (d[4])
        m_flag = 1'b0;
    end
    if (a == 8'h7c) begin
      m_al = d[5];
      m_ch = d[4:0];
    end
  endtask
  // Read data is taken in the one cycle after the strobe
  task rd(input logic [7:0] a, e);
    @(posedge core_clk);
    reg_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
    if (a == 8'h78) m_lock = 1'b1;
    if (a == 8'h79) m_lock = 1'b0;
  endtask
  // A locked pair drops the result and keeps the flag
  task conv(input logic [9:0] v);
    @(posedge core_clk);
    conv_in <= {1'b1, v};
    @(posedge core_clk);
    conv_in <= {1'b0, v};
    if (!m_lock) begin
      m_res = v;
      m_flag = 1'b1;
    end
  endtask
  task win(input int e);
    int s;
    s = n_start;
    repeat (4) @(posedge core_clk);
    chk(16'(n_start - s), 16'(e));
  endtask
  task flags(input logic [6:0] v, input int e);
    @(posedge core_clk);
    trig_flags <= v;
    win(e);
  endtask
  task finish_test();
    $display("mismatches %0d of %0d compares", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {rstn, reg_req, conv_in, trig_flags, pin_level} = '0;
    {m_res, m_ch, m_lock, m_flag, m_al, m_en, m_auto} = '0;
    seed = 32'h0000005f;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    for (k = 0; k < 8; k++) rd(8'h78 + 8'(k), 8'h00);
    wr(8'h78, 8'hff);
    rd(8'h78, 8'h00);
    // Random results, alignment flipped while locked
    for (i = 0; i < 6; i++) begin
      x = rnd();
      conv(x[25:16]);
      wr(8'h7c, {2'h0, x[5:0]});
      p = pres(m_res, m_al, m_ch);
      rd(8'h78, p[7:0]);
      wr(8'h7c, {2'h0, x[5:0] ^ 6'h20});
      p = pres(m_res, m_al, m_ch);
      rd(8'h79, p[15:8]);
      rd(8'h7a, {m_en, 1'b0, m_auto, m_flag, 4'h0});
      wr(8'h7a, 8'h10);
    end
    // Result arriving while locked
    x = rnd();
    conv(x[9:0]);
    p = pres(m_res, m_al, m_ch);
    rd(8'h78, p[7:0]);
    wr(8'h7a, 8'h10);
    conv(x[19:10]);
    rd(8'h7a, {m_en, 1'b0, m_auto, m_flag, 4'h0});
    rd(8'h79, p[15:8]);
    wr(8'h7b, 8'h45);
    rd(8'h7b, 8'h45);
    chk({15'h0, comparator_mux_enable}, 16'h0001);
    // Source codes 1 to 7, other flags first
    wr(8'h7a, 8'ha0);
    #1;
    chk({15'h0, converter_enable}, {15'h0, m_en});
    for (k = 1; k < 8; k++) begin
      wr(8'h7b, 8'(k));
      flags(~(7'h01 << (7 - k)), 0);
      flags(7'h7f, 1);
      flags(7'h00, 0);
    end
    wr(8'h7a, 8'h80);
    flags(7'h7f, 0);
    flags(7'h00, 0);
    wr(8'h7a, 8'h20);
    flags(7'h7f, 0);
    flags(7'h00, 0);
    // Source switch onto a set flag
    wr(8'h7a, 8'ha0);
    wr(8'h7b, 8'h01);
    flags(7'h20, 0);
    wr(8'h7b, 8'h02);
    win(1);
    flags(7'h00, 0);
    conv(10'h155);
    wr(8'h7b, 8'h00);
    win(0);
    wr(8'h7a, 8'hb0);
    conv(10'h2aa);
    win(1);
    // Pin masking
    for (i = 0; i < 4; i++) begin
      x = rnd();
      @(posedge core_clk);
      pin_level <= x[15:8];
      wr(8'h7e, x[7:0]);
      repeat (5) @(posedge core_clk);
      #1;
      chk({8'h00, pin_read_value}, {8'h00, x[15:8] & ~x[7:0]});
      chk({8'h00, pin_buffer_disable_bits}, {8'h00, x[7:0]});
      rd(8'h7e, x[7:0]);
    end
    finish_test();
  end
endmodule
`default_nettype wire
